// File: rtl/pfs_pin_select.sv
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pfs_consts.svh"
module pfs_pin_select
   import pfs_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  modePins,
   input  wire pfs_bus_t    busCtl,
   input  wire logic [10:0] gpioOut,
   input  wire logic [10:0] padIn,
   output logic      [10:0] padOut,
   output logic      [10:0] padOe,
   output logic      [10:0] gpioIn,
   output logic             busWaitN,
   output logic             portOutDisableN
);
   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [15:0] lowSel_r, lowSel_nxt;       // Low function select register.
   logic [15:0] highSel_r, highSel_nxt;     // High function select register.
   logic [15:0] dir_r, dir_nxt;             // Direction register.
   logic [31:0] prdata_r, prdata_nxt;       // Registered read data.
   logic        pready_r, pready_nxt;       // Registered ready.
   logic        pslverr_r, pslverr_nxt;     // Registered error.
   logic [1:0]  modeMeta_r, modeSync_r;     // Mode pin synchroniser.
   logic [10:0] padMeta_r, padSync_r;       // Pad input synchroniser.
   logic [10:0] padOut_r, padOut_nxt;       // Registered pad drive.
   logic [10:0] padOe_r, padOe_nxt;         // Registered pad enable.
   logic [10:0] gpioIn_r, gpioIn_nxt;       // Registered pin levels for software.
   logic        wait_r, wait_nxt;           // Registered wait input.
   logic        pod_r, pod_nxt;             // Registered output disable input.
   pfs_mode_t   mode;                       // Decoded operating mode.
   logic        expanded;                   // Any expanded mode.
   logic        romOff;                     // Expanded with ROM disabled.
   logic        romOn;                      // Expanded with ROM enabled.
   logic [1:0]  p5Sel;                      // Pin 5 select field.
   logic [10:0] busFn;                      // Pin carries a bus function.
   logic [10:0] busOutVal;                  // Bus value for each pin.
   logic [10:0] busIsOut;                   // Bus function is an output.
   logic        p5Pod;                      // Pin 5 is output disable input.
   logic        mapped;                     // Address hits a register.
   logic        accessDone;                 // Access phase completes now.

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the mode straps and the pads.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         modeMeta_r <= 2'h0;
         modeSync_r <= 2'h0;
         padMeta_r  <= 11'h000;
         padSync_r  <= 11'h000;
      end else begin
         modeMeta_r <= modePins;
         modeSync_r <= modeMeta_r;
         padMeta_r  <= padIn;
         padSync_r  <= padMeta_r;
      end
   end

   // Decodes the synchronised mode pins; both high codes mean single chip.
   always_comb begin
      unique case (modeSync_r)
         2'h0:    mode = PFS_EXP_ROM_OFF;
         2'h1:    mode = PFS_EXP_ROM_ON;
         default: mode = PFS_SINGLE_CHIP;
      endcase
      expanded = (mode != PFS_SINGLE_CHIP);
      romOff   = (mode == PFS_EXP_ROM_OFF);
      romOn    = (mode == PFS_EXP_ROM_ON);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Function selection for each pin.
   always_comb begin
      p5Sel     = lowSel_r[`PFS_LO_PIN5_HI:`PFS_LO_PIN5_LO];
      busFn     = 11'h000;
      busOutVal = 11'h000;
      busIsOut  = 11'h000;
      // Chip select 0 on pin 10 only in expanded mode.
      busFn[10]     = expanded & highSel_r[`PFS_HI_PIN10];
      busOutVal[10] = busCtl.chipSelectZeroN;
      busIsOut[10]  = 1'b1;
      // Read strobe on pin 9.
      busFn[9]      = expanded & highSel_r[`PFS_HI_PIN9];
      busOutVal[9]  = busCtl.readStrobeN;
      busIsOut[9]   = 1'b1;
      // Wait input on pin 8; the pad is never driven then.
      busFn[8]      = expanded & highSel_r[`PFS_HI_PIN8];
      // Write strobes on pins 7 and 6.
      busFn[7]      = expanded & lowSel_r[`PFS_LO_PIN7];
      busOutVal[7]  = busCtl.upperWriteN;
      busIsOut[7]   = 1'b1;
      busFn[6]      = expanded & lowSel_r[`PFS_LO_PIN6];
      busOutVal[6]  = busCtl.lowerWriteN;
      busIsOut[6]   = 1'b1;
      // Pin 5: address 21 or output disable input; the reserved code falls to general I/O.
      p5Pod         = !romOff && (p5Sel == `PFS_P5_POD);
      busIsOut[5]   = (romOff && p5Sel != `PFS_P5_RSVD) ||
                      (romOn && p5Sel == `PFS_P5_ADDR);
      busFn[5]      = busIsOut[5] | p5Pod;
      busOutVal[5]  = busCtl.addrHi[5];
      // Pins 4 to 0: address 20 to 16, forced with ROM off, per bit with ROM on.
      for (int i = 0; i < 5; i++) begin
         busFn[i]     = romOff | (romOn & lowSel_r[2*i]);
         busOutVal[i] = busCtl.addrHi[i];
         busIsOut[i]  = 1'b1;
      end
   end

   // Next pad drive, enable and the inputs handed back inside the chip.
   always_comb begin
      for (int i = 0; i < 11; i++) begin
         if (busFn[i]) begin
            padOut_nxt[i] = busIsOut[i] & busOutVal[i];
            padOe_nxt[i]  = busIsOut[i];
         end else begin
            padOut_nxt[i] = gpioOut[i];
            padOe_nxt[i]  = dir_r[i];
         end
      end
      gpioIn_nxt = padSync_r;
      // Inactive high when the pin does not carry the input function.
      wait_nxt   = busFn[8] ? padSync_r[8] : 1'b1;
      pod_nxt    = p5Pod ? padSync_r[5] : 1'b1;
   end

   // Registers the pad side so every output leaves a flip-flop.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         padOut_r <= 11'h000;
         padOe_r  <= 11'h000;
         gpioIn_r <= 11'h000;
         wait_r   <= 1'b1;
         pod_r    <= 1'b1;
      end else begin
         padOut_r <= padOut_nxt;
         padOe_r  <= padOe_nxt;
         gpioIn_r <= gpioIn_nxt;
         wait_r   <= wait_nxt;
         pod_r    <= pod_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Peripheral bus slave: one wait state, then ready with data or error.
   always_comb begin
      mapped      = (paddr == `PFS_OFF_LOW_SEL) || (paddr == `PFS_OFF_HIGH_SEL) ||
                    (paddr == `PFS_OFF_DIR);
      accessDone  = psel & penable & pready_r;
      pready_nxt  = psel & penable & ~pready_r;
      pslverr_nxt = psel & penable & ~pready_r & ~mapped;
      prdata_nxt  = 32'h0000_0000;
      if (psel && penable && !pready_r && !pwrite) begin
         unique case (paddr)
            `PFS_OFF_LOW_SEL:  prdata_nxt = {16'h0000, lowSel_r};
            `PFS_OFF_HIGH_SEL: prdata_nxt = {16'h0000, highSel_r};
            `PFS_OFF_DIR:      prdata_nxt = {16'h0000, dir_r};
            default:           prdata_nxt = 32'h0000_0000;
         endcase
      end
      lowSel_nxt  = lowSel_r;
      highSel_nxt = highSel_r;
      dir_nxt     = dir_r;
      // Writes land at the completing edge; reserved bits are dropped.
      if (accessDone && pwrite) begin
         unique case (paddr)
            `PFS_OFF_LOW_SEL:  lowSel_nxt  = pwdata[15:0] & `PFS_MASK_LOW_SEL;
            `PFS_OFF_HIGH_SEL: highSel_nxt = pwdata[15:0] & `PFS_MASK_HIGH_SEL;
            `PFS_OFF_DIR:      dir_nxt     = pwdata[15:0] & `PFS_MASK_DIR;
            default:           dir_nxt     = dir_r;
         endcase
      end
   end

   // Register file and bus answer flip-flops.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lowSel_r  <= `PFS_RST_LOW_SEL;
         highSel_r <= `PFS_RST_HIGH_SEL;
         dir_r     <= `PFS_RST_DIR;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         lowSel_r  <= lowSel_nxt;
         highSel_r <= highSel_nxt;
         dir_r     <= dir_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata          = prdata_r;
   assign pready          = pready_r;
   assign pslverr         = pslverr_r;
   assign padOut          = padOut_r;
   assign padOe           = padOe_r;
   assign gpioIn          = gpioIn_r;
   assign busWaitN        = wait_r;
   assign portOutDisableN = pod_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the pad routing and the register file.
   property p_cs0;
      @(posedge clock) disable iff (!rst_b)
      (expanded && highSel_r[`PFS_HI_PIN10]) |=>
         (padOe[10] && padOut[10] == $past(busCtl.chipSelectZeroN));
   endproperty
   a_cs0: assert property (p_cs0) else $error("Pin 10 not chip select");

   property p_rd;
      @(posedge clock) disable iff (!rst_b)
      (!expanded || !highSel_r[`PFS_HI_PIN9]) |=> (padOe[9] == $past(dir_r[9]));
   endproperty
   a_rd: assert property (p_rd) else $error("Pin 9 general I/O wrong");

   property p_wait;
      @(posedge clock) disable iff (!rst_b)
      (expanded && highSel_r[`PFS_HI_PIN8]) |=>
         (!padOe[8] && busWaitN == $past(padSync_r[8]));
   endproperty
   a_wait: assert property (p_wait) else $error("Wait input not routed");

   property p_rsvd;
      @(posedge clock) disable iff (!rst_b)
      pready && !pwrite |->
         (prdata[31:16] == 16'h0000 && (lowSel_r & ~`PFS_MASK_LOW_SEL) == 16'h0000 &&
          (highSel_r & ~`PFS_MASK_HIGH_SEL) == 16'h0000);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("Upper read bits not zero");

   property p_wrh;
      @(posedge clock) disable iff (!rst_b)
      (expanded && lowSel_r[`PFS_LO_PIN7] && lowSel_r[`PFS_LO_PIN6]) |=>
         (padOut[7] == $past(busCtl.upperWriteN) && padOut[6] == $past(busCtl.lowerWriteN));
   endproperty
   a_wrh: assert property (p_wrh) else $error("Write strobes not routed");

   property p_pod;
      @(posedge clock) disable iff (!rst_b)
      (mode == PFS_SINGLE_CHIP && p5Sel == `PFS_P5_POD) |=> !padOe[5];
   endproperty
   a_pod: assert property (p_pod) else $error("Pin 5 driven as input");

   property p_addr;
      @(posedge clock) disable iff (!rst_b)
      romOff |=> (padOe[4:0] == 5'h1F && padOut[4:0] == $past(busCtl.addrHi[4:0]));
   endproperty
   a_addr: assert property (p_addr) else $error("Address pins not forced");

   property p_single;
      @(posedge clock) disable iff (!rst_b)
      (mode == PFS_SINGLE_CHIP) |=> (padOe[4:0] == $past(dir_r[4:0]));
   endproperty
   a_single: assert property (p_single) else $error("Single chip pins not GPIO");

   property p_wr;
      @(posedge clock) disable iff (!rst_b)
      (accessDone && pwrite && paddr == `PFS_OFF_LOW_SEL) |=>
         (lowSel_r == ($past(pwdata[15:0]) & `PFS_MASK_LOW_SEL));
   endproperty
   a_wr: assert property (p_wr) else $error("Low select write lost");

   // Pin 5 carries address bit 21 for every legal code while ROM is off.
   property p_p5addr;
      @(posedge clock) disable iff (!rst_b)
      (romOff && p5Sel != `PFS_P5_RSVD) |=>
         (padOe[5] && padOut[5] == $past(busCtl.addrHi[5]));
   endproperty
   a_p5addr: assert property (p_p5addr) else $error("Pin 5 address not routed");

   // A general pin drives the software level exactly when its direction bit is set.
   property p_gpio;
      @(posedge clock) disable iff (!rst_b)
      !busFn[6] |=> (padOe[6] == $past(dir_r[6]) && padOut[6] == $past(gpioOut[6]));
   endproperty
   a_gpio: assert property (p_gpio) else $error("Pin 6 general I/O wrong");

   // A bus output pin drives even when its direction bit asks for an input.
   property p_busdir;
      @(posedge clock) disable iff (!rst_b)
      (busFn[7] && !dir_r[7]) |=> padOe[7];
   endproperty
   a_busdir: assert property (p_busdir) else $error("Bus pin follows direction bit");

endmodule // pfs_pin_select

// File: rtl/pfs_consts.svh
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
// Register byte offsets on the peripheral bus.
`define PFS_OFF_LOW_SEL   12'h000
`define PFS_OFF_HIGH_SEL  12'h004
`define PFS_OFF_DIR       12'h008
// Reset values of the registers.
`define PFS_RST_LOW_SEL   16'h5000
`define PFS_RST_HIGH_SEL  16'h0015
`define PFS_RST_DIR       16'h0000
// Writable bit masks; every other bit is reserved and reads as zero.
`define PFS_MASK_LOW_SEL  16'h5D55
`define PFS_MASK_HIGH_SEL 16'h0015
`define PFS_MASK_DIR      16'h07FF
// Field positions in the high select register.
`define PFS_HI_PIN10      4
`define PFS_HI_PIN9       2
`define PFS_HI_PIN8       0
// Field positions in the low select register.
`define PFS_LO_PIN7       14
`define PFS_LO_PIN6       12
`define PFS_LO_PIN5_HI    11
`define PFS_LO_PIN5_LO    10
// Pin 5 select codes.
`define PFS_P5_ADDR       2'h1
`define PFS_P5_POD        2'h2
`define PFS_P5_RSVD       2'h3
`endif

// File: rtl/pfs_pkg.sv
package pfs_pkg;
   // Operating mode of the chip, decoded from the mode pins.
   typedef enum logic [1:0] {
      PFS_EXP_ROM_OFF,
      PFS_EXP_ROM_ON,
      PFS_SINGLE_CHIP
   } pfs_mode_t;
   // Outputs of the bus controller that may reach the port F pads.
   typedef struct packed {
      logic [5:0] addrHi;           // Address bits 21 down to 16.
      logic       chipSelectZeroN;  // Chip select 0, active low.
      logic       readStrobeN;      // Read strobe, active low.
      logic       upperWriteN;      // Upper byte write strobe, active low.
      logic       lowerWriteN;      // Lower byte write strobe, active low.
   } pfs_bus_t;
endpackage

// File: verification/pfs_ext_bus_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far side of port F: memory and peripherals on the expansion bus.
module pfs_ext_bus_model
   import pfs_pkg::*;
(
   input  wire logic [10:0] padOut,
   input  wire logic [10:0] padOe,
   input  wire logic        waitReq,
   input  wire logic        podReq,
   input  wire logic [10:0] extLevel,
   output logic      [10:0] padIn
);
   logic [10:0] farDrive;  // Levels the far side puts on released pads.
   // Wait and output disable are active low requests from outside.
   always_comb begin
      farDrive    = extLevel;
      farDrive[8] = ~waitReq;
      farDrive[5] = ~podReq;
   end
   // A pad the device drives shows its level, else the far side's.
   assign padIn = (padOe & padOut) | (~padOe & farDrive);
endmodule // pfs_ext_bus_model

// File: verification/pfs_pin_select_tb.sv
`timescale 1ns/1ps
`include "pfs_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: APB register access and pad routing per mode.
module pfs_pin_select_tb
   import pfs_pkg::*;
;
   logic        clock, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  modePins;
   pfs_bus_t    busCtl;
   logic [10:0] gpioOut, padIn, padOut, padOe, gpioIn, extLevel;
   logic        busWaitN, portOutDisableN, err;
   int          miscompares, check_count;
   logic        waitReq, podReq;  // Far side requests on the wait and disable pins.
   logic [21:0] padExp;           // Expected pad enables and driven levels.
   logic [10:0] farExp;           // Expected far side levels on released pads.
   // Low select settings; pin 5 code 11 is never written by software.
   logic [15:0] cfgs [4] = '{16'h0000, 16'h5555, 16'h4800, 16'h1544};
   logic [15:0] lo, hi, dir;
   // Clock of 10 ns period.
   always #5 clock = ~clock;
   pfs_pin_select i_pfs_pin_select (.clock(clock), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .modePins(modePins),
      .busCtl(busCtl), .gpioOut(gpioOut), .padIn(padIn), .padOut(padOut),
      .padOe(padOe), .gpioIn(gpioIn), .busWaitN(busWaitN),
      .portOutDisableN(portOutDisableN));
   pfs_ext_bus_model i_pfs_ext_bus_model (.padOut(padOut), .padOe(padOe),
      .waitReq(waitReq), .podReq(podReq), .extLevel(extLevel), .padIn(padIn));
   ////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         miscompares++;
         end_of_test();
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Expected {padOe, driven padOut} from mode, registers and sources.
   function automatic logic [21:0] expPads(int m, logic [15:0] l, logic [15:0] h,
                                            logic [15:0] d, pfs_bus_t b,
                                            logic [10:0] g);
      logic [10:0] on, inOn, bv, oe;
      logic        ex, rOff, rOn;
      logic [1:0]  c;
      ex   = m < 2;
      rOff = m == 0;
      rOn  = m == 1;
      c    = l[11:10];
      for (int i = 0; i < 5; i++)
         on[i] = rOff | (rOn & l[2*i]);
      on[5]   = (rOff & c != 2'h3) | (rOn & c == 2'h1);
      on[6]   = ex & l[12];
      on[7]   = ex & l[14];
      on[8]   = 1'b0;
      on[9]   = ex & h[2];
      on[10]  = ex & h[4];
      inOn    = '0;
      inOn[5] = !rOff && c == 2'h2;
      inOn[8] = ex & h[0];
      bv = {b.chipSelectZeroN, b.readStrobeN, 1'b0, b.upperWriteN, b.lowerWriteN,
            b.addrHi};
      oe = on | (d[10:0] & ~on & ~inOn);
      return {oe, ((bv & on) | (g & ~on)) & oe};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      clock = 1'b0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; modePins = 2'h0; busCtl = '0;
      gpioOut = 11'h000; extLevel = 11'h2B4; miscompares = 0; check_count = 0;
      waitReq = 1'b0; podReq = 1'b0;
      repeat (10) @(posedge clock);
      chk(32'(padOe), 32'h0);  // Pads released while in reset.
      chk(32'(busWaitN), 32'h1);
      rst_b <= 1'b1;
      apb(1'b0, `PFS_OFF_LOW_SEL, 32'h0);
      chk(rd, 32'h00005000);
      apb(1'b0, `PFS_OFF_HIGH_SEL, 32'h0);
      chk(rd, 32'h00000015);
      apb(1'b1, 12'h00C, 32'hFFFFFFFF);
      chk(32'(err), 32'h1);  // Unmapped address flags an error.
      apb(1'b0, 12'h00C, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `PFS_OFF_HIGH_SEL, 32'hFFFFFFFF);
      apb(1'b0, `PFS_OFF_HIGH_SEL, 32'h0);
      chk(rd, 32'h00000015);
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 4; k++) begin
            lo  = cfgs[k];
            hi  = k[0] ? 16'h0015 : 16'h0000;
            dir = k[1] ? 16'hFFFF : 16'h0555;
            modePins <= m[1:0];
            busCtl   <= 10'h2A5 ^ (10'h0F3 << k);
            gpioOut  <= 11'h5A3 ^ (11'h0C6 << m);
            waitReq  <= m[0] ^ k[1];
            podReq   <= m[0];
            apb(1'b1, `PFS_OFF_LOW_SEL, {16'hFFFF, lo});
            apb(1'b1, `PFS_OFF_HIGH_SEL, {16'h0, hi});
            apb(1'b1, `PFS_OFF_DIR, {16'h0, dir});
            apb(1'b0, `PFS_OFF_LOW_SEL, 32'h0);
            chk(rd, {16'h0, lo & 16'h5D55});
            apb(1'b0, `PFS_OFF_DIR, 32'h0);
            chk(rd, {16'h0, dir & 16'h07FF});
            repeat (6) @(posedge clock);
            padExp    = expPads(m, lo, hi, dir, busCtl, gpioOut);
            farExp    = extLevel;
            farExp[8] = ~waitReq;
            farExp[5] = ~podReq;
            chk(32'(padOe), 32'(padExp[21:11]));
            chk(32'(padOut & padOe), 32'(padExp[10:0]));
            chk(32'(busWaitN), 32'(!(m < 2 && hi[0] && waitReq)));
            chk(32'(portOutDisableN), 32'(!(m > 0 && lo[11:10] == 2'h2 && podReq)));
            chk(32'(gpioIn), 32'(padExp[10:0] | (~padExp[21:11] & farExp)));
         end
      end
      end_of_test();
   end
endmodule // pfs_pin_select_tb
